// File: include/sdlc_defines.vh
// Purpose: constants for the serial dac load control block
// Assumes: 20 MHz system clock
// Notes:   frame format msb first: rw, 3-bit address, 20-bit data
`ifndef SDLC_DEFINES_VH
`define SDLC_DEFINES_VH

`define SDLC_FRAME_BITS     24
`define SDLC_DATA_BITS      20
`define SDLC_RW_BIT         23
`define SDLC_ADDR_MSB       22
`define SDLC_ADDR_LSB       20
`define SDLC_ADDR_W         3
`define SDLC_DATA_MSB       19

`define SDLC_ADDR_DAC       3'h1
`define SDLC_ADDR_CTRL      3'h2
`define SDLC_ADDR_PRESET    3'h4

`define SDLC_CTRL_TWOS_BIT  1

`define SDLC_DAC_RESET      20'h00000
`define SDLC_CTRL_RESET     20'h00000
`define SDLC_PRESET_RESET   20'h00000
`define SDLC_MIDSCALE       20'h80000

`endif

// File: rtl/sdlc_regfile.v
// Purpose: small register store holding dac, control and preset words
// Assumes: single write port, registered read port
// Notes:   read data comes out of a register, one cycle after the address
`timescale 1ns/1ps
`include "sdlc_defines.vh"

module sdlc_regfile #(
    parameter WIDTH = 20,
    parameter ADDR_W = 3
) (
    input  wire              clk_in,
    input  wire              rst_n_in,
    input  wire              wr_en_in,
    input  wire [ADDR_W-1:0] wr_addr_in,
    input  wire [WIDTH-1:0]  wr_data_in,
    input  wire [ADDR_W-1:0] rd_addr_in,
    output reg  [WIDTH-1:0]  rd_data_out
);
    localparam DEPTH = 1 << ADDR_W;
    wire [WIDTH*DEPTH-1:0] flat;
    genvar i;

    generate
        for (i = 0; i < DEPTH; i = i + 1) begin : g_word
            // each word owns its register, so every word has one driver
            reg [WIDTH-1:0] word;
            always @(posedge clk_in) begin
                if (!rst_n_in) begin
                    word <= {WIDTH{1'b0}};
                end else if (wr_en_in && wr_addr_in == i) begin
                    word <= wr_data_in;
                end
            end
            assign flat[i*WIDTH +: WIDTH] = word;
        end
    endgenerate

    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            rd_data_out <= {WIDTH{1'b0}};
        end else begin
            rd_data_out <= flat[rd_addr_in*WIDTH +: WIDTH];
        end
    end
endmodule

// File: rtl/sdlc_top.v
// Purpose: serial write link, input and dac registers, load and preset control
// Assumes: link pins asynchronous to CLOCK_IN, sampled through two flip-flops
// Notes:   sclk must stay well below CLOCK_IN/4 for edges to be seen
//
// Contract
// R1: while reset is low all logic returns to its power-on state.
// R2: preset_force_n low loads the dac register with the preset word at once.
// R3: the preset word is taken in binary or twos complement per control coding.
// R4: with output_load_n held low the dac register updates on frame select rise.
// R5: with output_load_n high in a frame only the input register updates.
// R6: the serial input shift register is 24 bits long.
// R7: serial input is sampled on each falling edge of the serial clock.
// R8: serial output changes on each rising edge of the serial clock.
// R9: shift data is taken only while frame select stays low.
// R10: the host keeps the write serial clock at or below 35 MHz.
// R11: a frame is rw flag, 3-bit address, 20-bit data, msb first.
// R12: the host keeps the readback serial clock at or below 16 MHz.
// R13: only frames of exactly 24 falling edges take effect.
`timescale 1ns/1ps
`include "sdlc_defines.vh"

module sdlc_top #(
    parameter FRAME_BITS = `SDLC_FRAME_BITS,
    parameter DATA_BITS  = `SDLC_DATA_BITS
) (
    // system
    input  wire                 CLOCK_IN,
    input  wire                 RESET_N_IN,
    // serial link
    input  wire                 FRAME_SEL_N_IN,
    input  wire                 SERIAL_CLK_IN,
    input  wire                 SERIAL_IN,
    output reg                  SERIAL_OUT,
    output reg                  SERIAL_OUT_OE_OUT,
    // load and preset controls
    input  wire                 OUTPUT_LOAD_N_IN,
    input  wire                 PRESET_FORCE_N_IN,
    // dac code toward the analog core
    output reg  [DATA_BITS-1:0] DAC_CODE_OUT,
    output reg                  DAC_UPDATE_OUT
);
    localparam ST_IDLE  = 3'b001;
    localparam ST_SHIFT = 3'b010;
    localparam ST_DONE  = 3'b100;
    // readback counter marks: armed after a read frame, then one count per rise
    localparam [4:0] RD_START = FRAME_BITS[4:0];
    localparam [4:0] RD_ARM   = RD_START + 5'h01;

    // two-stage synchronisers for all input pins except RESET_N_IN
    reg [1:0] sync_fs;
    reg [1:0] sync_sck;
    reg [1:0] sync_sdi;
    reg [1:0] sync_ld;
    reg [1:0] sync_clr;
    reg       fs_d;
    reg       sck_d;
    reg       ld_d;

    reg [2:0]            state;
    reg [FRAME_BITS-1:0] shift;
    reg [4:0]            bit_cnt;
    reg                  cnt_over;
    reg [DATA_BITS-1:0]  input_reg;
    reg                  load_pending;
    reg                  twos_coding;
    reg [DATA_BITS-1:0]  preset_word;
    reg [DATA_BITS-1:0]  read_word;
    reg [4:0]            read_cnt;

    wire fs_n   = sync_fs[1];
    wire sck    = sync_sck[1];
    wire sdi    = sync_sdi[1];
    wire ld_n   = sync_ld[1];
    wire clr_n  = sync_clr[1];
    wire fs_fall  = fs_d & ~fs_n;
    wire fs_rise  = ~fs_d & fs_n;
    wire sck_fall = sck_d & ~sck;
    wire sck_rise = ~sck_d & sck;
    wire ld_fall  = ld_d & ~ld_n;

    // R11: rw flag, address, data fields
    wire                       frame_ok = (bit_cnt == FRAME_BITS) && !cnt_over;
    wire                       is_read  = shift[`SDLC_RW_BIT];
    wire [`SDLC_ADDR_W-1:0]    addr     = shift[`SDLC_ADDR_MSB:`SDLC_ADDR_LSB];
    wire [DATA_BITS-1:0]       data     = shift[`SDLC_DATA_MSB:0];
    wire                       commit   = (state == ST_DONE) && frame_ok && !is_read;
    wire [DATA_BITS-1:0]       rd_data;

    // R3: preset interpreted per coding; twos-complement zero is midscale
    wire [DATA_BITS-1:0] preset_code = twos_coding ? (preset_word ^ `SDLC_MIDSCALE)
                                                   : preset_word;
    wire [DATA_BITS-1:0] input_code  = twos_coding ? (input_reg ^ `SDLC_MIDSCALE)
                                                   : input_reg;

    // store keeps every written word so readback returns it
    sdlc_regfile #(
        .WIDTH  (DATA_BITS),
        .ADDR_W (`SDLC_ADDR_W)
    ) u_store (
        .clk_in      (CLOCK_IN),
        .rst_n_in    (RESET_N_IN),
        .wr_en_in    (commit),
        .wr_addr_in  (addr),
        .wr_data_in  (data),
        .rd_addr_in  (addr),
        .rd_data_out (rd_data)
    );

    always @(posedge CLOCK_IN) begin
        // R1: synchronous return to power-on state
        if (!RESET_N_IN) begin
            sync_fs  <= 2'h3;
            // link clock idles high; matching it avoids a false rise after reset
            sync_sck <= 2'h3;
            sync_sdi <= 2'h0;
            sync_ld  <= 2'h3;
            sync_clr <= 2'h3;
            fs_d     <= 1'b1;
            sck_d    <= 1'b1;
            ld_d     <= 1'b1;
        end else begin
            sync_fs  <= {sync_fs[0], FRAME_SEL_N_IN};
            sync_sck <= {sync_sck[0], SERIAL_CLK_IN};
            sync_sdi <= {sync_sdi[0], SERIAL_IN};
            sync_ld  <= {sync_ld[0], OUTPUT_LOAD_N_IN};
            sync_clr <= {sync_clr[0], PRESET_FORCE_N_IN};
            fs_d     <= fs_n;
            sck_d    <= sck;
            ld_d     <= ld_n;
        end
    end

    always @(posedge CLOCK_IN) begin
        if (!RESET_N_IN) begin
            state    <= ST_IDLE;
            shift    <= {FRAME_BITS{1'b0}};
            bit_cnt  <= 5'h00;
            cnt_over <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (fs_fall) begin
                        state    <= ST_SHIFT;
                        bit_cnt  <= 5'h00;
                        cnt_over <= 1'b0;
                    end
                end
                ST_SHIFT: begin
                    if (fs_rise) begin
                        state <= ST_DONE;
                    // R9: shift only while frame select low
                    end else if (sck_fall) begin
                        // R7: sample serial input on falling edge
                        // R6: 24-bit shift register, msb first (R11)
                        shift <= {shift[FRAME_BITS-2:0], sdi};
                        if (bit_cnt == FRAME_BITS) begin
                            cnt_over <= 1'b1;
                        end else begin
                            bit_cnt <= bit_cnt + 5'h01;
                        end
                    end
                end
                ST_DONE: begin
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // control word holds the coding select; preset word lives here too
    always @(posedge CLOCK_IN) begin
        if (!RESET_N_IN) begin
            input_reg    <= `SDLC_DAC_RESET;
            twos_coding  <= 1'b0;
            preset_word  <= `SDLC_PRESET_RESET;
            load_pending <= 1'b0;
            DAC_CODE_OUT   <= `SDLC_DAC_RESET;
            DAC_UPDATE_OUT <= 1'b0;
        end else begin
            DAC_UPDATE_OUT <= 1'b0;
            // R13: only a frame of exactly 24 edges commits
            if (commit && addr == `SDLC_ADDR_CTRL) begin
                twos_coding <= data[`SDLC_CTRL_TWOS_BIT];
            end
            if (commit && addr == `SDLC_ADDR_PRESET) begin
                preset_word <= data;
            end
            // R2: preset force wins over any load
            if (!clr_n) begin
                DAC_CODE_OUT   <= preset_code;
                DAC_UPDATE_OUT <= 1'b1;
                load_pending   <= 1'b0;
            end else if (commit && addr == `SDLC_ADDR_DAC) begin
                input_reg <= data;
                if (!ld_n) begin
                    // R4: load low, update on frame select rise
                    DAC_CODE_OUT   <= twos_coding ? (data ^ `SDLC_MIDSCALE) : data;
                    DAC_UPDATE_OUT <= 1'b1;
                    // stale deferral would replay on a later load fall
                    load_pending   <= 1'b0;
                end else begin
                    // R5: load high, hold until load falls
                    load_pending <= 1'b1;
                end
            end else if (ld_fall && load_pending) begin
                // R5: deferred transfer on load falling edge
                DAC_CODE_OUT   <= input_code;
                DAC_UPDATE_OUT <= 1'b1;
                load_pending   <= 1'b0;
            end
        end
    end

    // readback: a read frame latches the word, the next frame shifts it out
    always @(posedge CLOCK_IN) begin
        if (!RESET_N_IN) begin
            read_word         <= {DATA_BITS{1'b0}};
            read_cnt          <= 5'h00;
            SERIAL_OUT        <= 1'b0;
            SERIAL_OUT_OE_OUT <= 1'b0;
        end else if (state == ST_DONE && frame_ok && is_read) begin
            read_cnt <= RD_ARM;
        end else if (read_cnt == RD_ARM && state == ST_IDLE) begin
            // store read data is valid one cycle after the frame closed
            read_word <= rd_data;
            read_cnt  <= RD_START;
        end else if (fs_rise) begin
            read_cnt          <= 5'h00;
            SERIAL_OUT_OE_OUT <= 1'b0;
        end else if (state == ST_SHIFT && sck_rise && read_cnt != 5'h00) begin
            // R8: serial output changes on rising edge
            SERIAL_OUT_OE_OUT <= 1'b1;
            if (read_cnt > DATA_BITS) begin
                SERIAL_OUT <= 1'b0;
            end else begin
                SERIAL_OUT <= read_word[read_cnt[4:0] - 5'h01];
            end
            read_cnt <= read_cnt - 5'h01;
        end
    end
endmodule

// File: tb/sdlc_sva.sv
// Purpose: port assertions for the serial dac load block
// Assumes: 20 MHz clock, synchronous active-low reset
// Notes:   windows allow for the two-flop pin synchroniser
`timescale 1ns/1ps
module sdlc_sva #(
    parameter DATA_BITS = 20
) (
    input logic                 CLOCK_IN,
    input logic                 RESET_N_IN,
    input logic                 FRAME_SEL_N_IN,
    input logic                 SERIAL_CLK_IN,
    input logic                 SERIAL_IN,
    input logic                 SERIAL_OUT,
    input logic                 SERIAL_OUT_OE_OUT,
    input logic                 OUTPUT_LOAD_N_IN,
    input logic                 PRESET_FORCE_N_IN,
    input logic [DATA_BITS-1:0] DAC_CODE_OUT,
    input logic                 DAC_UPDATE_OUT
);
    sequence s_fs_idle;
        FRAME_SEL_N_IN [*8];
    endsequence
    sequence s_load_held;
        (OUTPUT_LOAD_N_IN && PRESET_FORCE_N_IN) [*8];
    endsequence
    sequence s_frame_quiet;
        (!FRAME_SEL_N_IN && PRESET_FORCE_N_IN && OUTPUT_LOAD_N_IN) [*6];
    endsequence
    property p_reset;
        @(posedge CLOCK_IN) !RESET_N_IN |=> DAC_CODE_OUT == 0 && !DAC_UPDATE_OUT && !SERIAL_OUT_OE_OUT;
    endproperty
    property p_code_pulse;
        @(posedge CLOCK_IN) disable iff (!RESET_N_IN) $changed(DAC_CODE_OUT) |-> DAC_UPDATE_OUT;
    endproperty
    property p_oe_off;
        @(posedge CLOCK_IN) disable iff (!RESET_N_IN) $rose(FRAME_SEL_N_IN) |-> ##[1:6] !SERIAL_OUT_OE_OUT;
    endproperty
    property p_oe_idle;
        @(posedge CLOCK_IN) disable iff (!RESET_N_IN) s_fs_idle |-> !SERIAL_OUT_OE_OUT;
    endproperty
    property p_preset;
        @(posedge CLOCK_IN) disable iff (!RESET_N_IN) !PRESET_FORCE_N_IN [*6] |-> DAC_UPDATE_OUT;
    endproperty
    property p_out_hold;
        @(posedge CLOCK_IN) disable iff (!RESET_N_IN) $changed(SERIAL_OUT) |->
            SERIAL_OUT_OE_OUT && $past(SERIAL_CLK_IN, 3) && !$past(SERIAL_CLK_IN, 4);
    endproperty
    property p_hold_off;
        @(posedge CLOCK_IN) disable iff (!RESET_N_IN) s_load_held |-> !DAC_UPDATE_OUT;
    endproperty
    property p_no_early;
        @(posedge CLOCK_IN) disable iff (!RESET_N_IN) s_frame_quiet |-> !DAC_UPDATE_OUT;
    endproperty
    property p_one_pulse;
        @(posedge CLOCK_IN) disable iff (!RESET_N_IN)
            PRESET_FORCE_N_IN [*5] ##0 DAC_UPDATE_OUT |=> !DAC_UPDATE_OUT;
    endproperty
    a_reset:      assert property (p_reset) else $error("outputs not cleared by reset");
    a_code_pulse: assert property (p_code_pulse) else $error("code moved without pulse");
    a_oe_off:     assert property (p_oe_off) else $error("readback drive stuck on");
    a_oe_idle:    assert property (p_oe_idle) else $error("readback drive outside frame");
    a_preset:     assert property (p_preset) else $error("preset force not applied");
    a_out_hold:   assert property (p_out_hold) else $error("serial out moved without rise");
    a_no_early:   assert property (p_no_early) else $error("update inside open frame");
    a_one_pulse:  assert property (p_one_pulse) else $error("update pulse too long");
    a_hold_off:   assert property (p_hold_off) else $error("update while load held high");
endmodule
bind sdlc_top sdlc_sva #(.DATA_BITS(DATA_BITS)) i_sdlc_sva (
    .CLOCK_IN(CLOCK_IN), .RESET_N_IN(RESET_N_IN), .FRAME_SEL_N_IN(FRAME_SEL_N_IN),
    .SERIAL_CLK_IN(SERIAL_CLK_IN), .SERIAL_IN(SERIAL_IN), .SERIAL_OUT(SERIAL_OUT),
    .SERIAL_OUT_OE_OUT(SERIAL_OUT_OE_OUT), .OUTPUT_LOAD_N_IN(OUTPUT_LOAD_N_IN),
    .PRESET_FORCE_N_IN(PRESET_FORCE_N_IN), .DAC_CODE_OUT(DAC_CODE_OUT),
    .DAC_UPDATE_OUT(DAC_UPDATE_OUT));

// File: tb/sdlc_host.sv
// Purpose: host serial master model
// Assumes: driven on the falling edge of the system clock
// Notes:   link clock idles high and stands still between frames
`timescale 1ns/1ps
module sdlc_host (
    input  logic clk_in,
    input  logic so_in,
    output logic fs_n_out,
    output logic sclk_out,
    output logic sdi_out
);
    initial begin
        fs_n_out = 1'b1;
        sclk_out = 1'b1;
        sdi_out  = 1'b0;
    end
    task automatic phase();
        repeat (4) @(negedge clk_in);
    endtask
    task automatic frame(input logic [31:0] word, input int nbits, output logic [23:0] rd);
        rd = 24'h000000;
        fs_n_out = 1'b0;
        for (int i = nbits - 1; i >= 0; i--) begin
            sdi_out = word[i];
            phase();
            if (i != nbits - 1) rd = {rd[22:0], so_in};
            sclk_out = 1'b0;
            phase();
            sclk_out = 1'b1;
        end
        phase();
        rd = {rd[22:0], so_in};
        fs_n_out = 1'b1;
        // released line must not keep its last level
        sdi_out = ~sdi_out;
    endtask
endmodule

// File: tb/tb.sv
// Purpose: self-checking bench for the serial dac load block
// Assumes: 20 MHz clock, inputs driven on falling edges
// Notes:   host model makes the 400 ns link clock
`timescale 1ns/1ps
module tb;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        load_n = 1'b0;
    logic        force_n = 1'b1;
    logic        fs_n, sclk, sdi, so, oe, upd, seen;
    logic [19:0] code;
    logic [23:0] rd;
    int          num_errors = 0;
    int          total_checks = 0;
    int          cycles = 0;
    always #25 clk = ~clk;
    sdlc_top i_sdlc_top (.CLOCK_IN(clk), .RESET_N_IN(rst_n), .FRAME_SEL_N_IN(fs_n),
        .SERIAL_CLK_IN(sclk), .SERIAL_IN(sdi), .SERIAL_OUT(so), .SERIAL_OUT_OE_OUT(oe),
        .OUTPUT_LOAD_N_IN(load_n), .PRESET_FORCE_N_IN(force_n), .DAC_CODE_OUT(code),
        .DAC_UPDATE_OUT(upd));
    sdlc_host i_sdlc_host (.clk_in(clk), .so_in(so), .fs_n_out(fs_n), .sclk_out(sclk),
        .sdi_out(sdi));
    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic wait_upd();
        seen = 1'b0;
        repeat (12) begin
            @(negedge clk);
            if (upd === 1'b1) seen = 1'b1;
        end
    endtask
    task automatic wr(input logic [2:0] addr, input logic [19:0] data);
        i_sdlc_host.frame({8'h00, 1'b0, addr, data}, 24, rd);
        wait_upd();
    endtask
    task automatic t_reset();
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        check({4'h0, code}, 24'h000000);
        check({21'h0, so, oe, upd}, 24'h000000);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
    endtask
    task automatic t_load_low();
        wr(3'h1, 20'hFFFFF);
        check({23'h0, seen}, 24'h000001);
        check({4'h0, code}, 24'h0FFFFF);
        wr(3'h1, 20'hA5A5A);
        check({4'h0, code}, 24'h0A5A5A);
    endtask
    task automatic t_bad_len();
        // one short, one long frame
        for (int n = 23; n <= 25; n += 2) begin
            i_sdlc_host.frame({8'h00, 4'h1, 20'h00001}, n, rd);
            wait_upd();
            check({23'h0, seen}, 24'h000000);
            check({4'h0, code}, 24'h0A5A5A);
        end
    endtask
    task automatic t_load_high();
        load_n = 1'b1;
        wr(3'h1, 20'h12345);
        check({23'h0, seen}, 24'h000000);
        check({4'h0, code}, 24'h0A5A5A);
        load_n = 1'b0;
        wait_upd();
        check({23'h0, seen}, 24'h000001);
        check({4'h0, code}, 24'h012345);
    endtask
    task automatic t_preset();
        wr(3'h4, 20'h0F0F0);
        for (int c = 0; c < 2; c++) begin
            wr(3'h2, c ? 20'h00002 : 20'h00000);
            force_n = 1'b0;
            wait_upd();
            check({23'h0, seen}, 24'h000001);
            check({4'h0, code}, c ? 24'h08F0F0 : 24'h00F0F0);
            force_n = 1'b1;
            wait_upd();
        end
    endtask
    task automatic t_read();
        // address repeated in the data frame
        i_sdlc_host.frame({8'h00, 4'h9, 20'h00000}, 24, rd);
        wait_upd();
        i_sdlc_host.frame({8'h00, 4'h9, 20'h00000}, 24, rd);
        check(rd, 24'h012345);
        wait_upd();
    endtask
    initial begin
        t_reset();
        t_load_low();
        t_bad_len();
        t_load_high();
        t_preset();
        t_read();
        t_reset();
        results();
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            num_errors++;
            results();
        end
    end
endmodule
